//--- phy_regs_pkg.sv
// Constants for the identifier and auto-negotiation register bank.
// Assumes a management interface that reads and writes 16-bit words.
// How it works
// - Identifier bits 15:10 return fixed organisation identifier bits 19 to 24.
// - Identifier bits 9:4 return a fixed six-bit model number, msb at 9.
// - Identifier bits 3:0 return a fixed four-bit revision, msb at 3.
// - Advertisement contents drive the word offered to the link partner.
// - Advertisement bit 15 reads zero and ignores writes.
// - Advertisement bit 14 is read-only, reset 0, set by negotiation logic.
// - Advertisement bit 13 is a writable remote fault flag, reset 0.
// - Advertisement bits 12:11 reserved; software writes 0, ignores reads.
// - Advertisement bit 10 is a writable flow-control flag, reset 0.
// - Advertisement bit 9 always reads zero.
// - Advertisement bits 8:5 are writable ability flags, each reset 1.
// - Advertisement bits 4:0 writable selector, reset to the CSMA/CD code.
// - Partner ability register loads the partner's received ability word.
// - Partner bit 15 shows partner next page, read-only, reset 0.
// - Partner bit 14 follows received acknowledge, read-only, reset 0.
// - Partner bit 13 reports partner remote fault, read-only, reset 0.
// - Partner bit 10 is flow-control ability, writable, reset 0.
// - Partner bits 9:5 report partner abilities, read-only, reset 0.
// - Partner bits 4:0 hold partner selector, read-only, reset 0.

`default_nettype none

package phy_regs_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int REG_W = 16;
  localparam logic [ADDR_W-1:0] OFF_PHY_IDENTIFIER_LOW = 5'h03;
  localparam logic [ADDR_W-1:0] OFF_AUTONEG_ADVERTISE = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_LINK_PARTNER_ABILITY = 5'h05;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_NEXT_PAGE = 15;
  localparam int BIT_ACK = 14;
  localparam int BIT_REMOTE_FAULT = 13;
  localparam int RESV_HI = 12;
  localparam int RESV_LO = 11;
  localparam int BIT_FLOW_CONTROL = 10;
  localparam int BIT_FOUR_PAIR = 9;
  localparam int ABIL_HI = 8;
  localparam int ABIL_LO = 5;
  localparam int LP_ABIL_HI = 9;
  localparam int SEL_HI = 4;
  localparam int SEL_LO = 0;
  localparam int ORG_HI = 15;
  localparam int ORG_LO = 10;
  localparam int MODEL_HI = 9;
  localparam int MODEL_LO = 4;
  localparam int REV_HI = 3;
  localparam int REV_LO = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [0:0] RST_FLAG_OFF = 1'h0;
  localparam logic [1:0] RST_RESV = 2'h0;
  localparam logic [3:0] RST_ABIL = 4'hF;
  localparam logic [4:0] RST_SELECTOR = 5'h01;
  localparam logic [REG_W-1:0] RST_PARTNER = 16'h0000;
  localparam logic [REG_W-1:0] WORD_ZERO = 16'h0000;
endpackage

`default_nettype wire

//--- rw_field.sv
// One writable register field with hardware load.
// Assumes write and load strobes are synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none

module rw_field
#(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VALUE = '0
)
(
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic wr_en, // Management write strobe
  input wire logic [W-1:0] wr_data, // Management write data
  input wire logic load_en, // Hardware update strobe
  input wire logic [W-1:0] load_data, // Hardware update data
  output logic [W-1:0] q // Field value
);
  // -------------------------------------------------------------
  // Storage; hardware update wins over a write in the same cycle
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      q <= RESET_VALUE;
    else if (load_en)
      q <= load_data;
    else if (wr_en)
      q <= wr_data;
  end
endmodule

`default_nettype wire

//--- phy_id_autoneg_regs.sv
// Identifier, advertisement and partner ability registers of the PHY.
// Assumes management strobes and negotiation inputs on clk_sys.
`timescale 1ns/1ns
`default_nettype none

module phy_id_autoneg_regs
  import phy_regs_pkg::*;
#(
  parameter logic [5:0] ORG_ID_LOW_BITS = 6'h2A, // Arbitrary value
  parameter logic [5:0] MODEL_NUMBER = 6'h15, // Arbitrary value
  parameter logic [3:0] MODEL_REVISION = 4'h3 // Arbitrary value
)
(
  input wire logic clk_sys, // System clock, 250 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic [ADDR_W-1:0] mgmt_addr, // Register address
  input wire logic mgmt_wr, // Write strobe, one cycle
  input wire logic [REG_W-1:0] mgmt_wdata, // Write data
  input wire logic mgmt_rd, // Read strobe, one cycle
  output logic [REG_W-1:0] mgmt_rdata, // Read data, registered
  output logic mgmt_rvalid, // Read data valid pulse
  input wire logic an_ack_set, // Negotiation sets local ack
  input wire logic an_ack_clr, // Negotiation clears local ack
  input wire logic lp_word_valid, // Partner word received pulse
  input wire logic [REG_W-1:0] lp_word, // Partner received word
  input wire logic lp_ack_valid, // Partner ack update pulse
  input wire logic lp_ack, // Partner ack value
  output logic [REG_W-1:0] adv_word // Word offered to partner
);
  // -------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------
  logic hit_adv;
  logic hit_lp;
  logic wr_adv;
  logic wr_lp;

  assign hit_adv = (mgmt_addr == OFF_AUTONEG_ADVERTISE);
  assign hit_lp = (mgmt_addr == OFF_LINK_PARTNER_ABILITY);
  assign wr_adv = mgmt_wr && hit_adv;
  assign wr_lp = mgmt_wr && hit_lp;

  // -------------------------------------------------------------
  // Advertisement fields
  // -------------------------------------------------------------
  logic [0:0] adv_rf;
  logic [1:0] adv_resv;
  logic [0:0] adv_fcs;
  logic [3:0] adv_abil;
  logic [4:0] adv_sel;
  logic adv_ack;

  // Local remote fault flag
  rw_field #(.W(1), .RESET_VALUE(RST_FLAG_OFF)) u_adv_rf
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_adv),
    .wr_data(mgmt_wdata[BIT_REMOTE_FAULT]),
    .load_en(1'b0),
    .load_data(RST_FLAG_OFF),
    .q(adv_rf)
  );

  // Reserved pair, stored so reads give back what was written
  rw_field #(.W(2), .RESET_VALUE(RST_RESV)) u_adv_resv
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_adv),
    .wr_data(mgmt_wdata[RESV_HI:RESV_LO]),
    .load_en(1'b0),
    .load_data(RST_RESV),
    .q(adv_resv)
  );

  // Flow control ability
  rw_field #(.W(1), .RESET_VALUE(RST_FLAG_OFF)) u_adv_fcs
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_adv),
    .wr_data(mgmt_wdata[BIT_FLOW_CONTROL]),
    .load_en(1'b0),
    .load_data(RST_FLAG_OFF),
    .q(adv_fcs)
  );

  // Speed and duplex abilities
  rw_field #(.W(4), .RESET_VALUE(RST_ABIL)) u_adv_abil
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_adv),
    .wr_data(mgmt_wdata[ABIL_HI:ABIL_LO]),
    .load_en(1'b0),
    .load_data(RST_ABIL),
    .q(adv_abil)
  );

  // Protocol selector
  rw_field #(.W(5), .RESET_VALUE(RST_SELECTOR)) u_adv_sel
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_adv),
    .wr_data(mgmt_wdata[SEL_HI:SEL_LO]),
    .load_en(1'b0),
    .load_data(RST_SELECTOR),
    .q(adv_sel)
  );

  // Local acknowledge owned by negotiation; set wins over clear
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      adv_ack <= 1'b0;
    else if (an_ack_set)
      adv_ack <= 1'b1;
    else if (an_ack_clr)
      adv_ack <= 1'b0;
  end

  // -------------------------------------------------------------
  // Advertised word towards the partner
  // -------------------------------------------------------------
  logic [REG_W-1:0] adv_value;

  // Next page and four-pair ability forced low
  always_comb
  begin
    adv_value = WORD_ZERO;
    adv_value[BIT_NEXT_PAGE] = 1'b0;
    adv_value[BIT_ACK] = adv_ack;
    adv_value[BIT_REMOTE_FAULT] = adv_rf[0];
    adv_value[RESV_HI:RESV_LO] = adv_resv;
    adv_value[BIT_FLOW_CONTROL] = adv_fcs[0];
    adv_value[BIT_FOUR_PAIR] = 1'b0;
    adv_value[ABIL_HI:ABIL_LO] = adv_abil;
    adv_value[SEL_HI:SEL_LO] = adv_sel;
  end

  // Offered word registered, reserved bits sent as zero
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      adv_word <= WORD_ZERO;
    else
    begin
      adv_word <= adv_value;
      adv_word[RESV_HI:RESV_LO] <= RST_RESV;
    end
  end

  // -------------------------------------------------------------
  // Partner ability register
  // -------------------------------------------------------------
  logic [REG_W-1:0] lp_ro;
  logic [0:0] lp_fcs;

  // Read-only part loaded from received bursts
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      lp_ro <= RST_PARTNER;
    else
    begin
      if (lp_word_valid)
        lp_ro <= lp_word;
      if (lp_ack_valid)
        lp_ro[BIT_ACK] <= lp_ack;
    end
  end

  // Partner flow control: writable, received value wins
  rw_field #(.W(1), .RESET_VALUE(RST_FLAG_OFF)) u_lp_fcs
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_lp),
    .wr_data(mgmt_wdata[BIT_FLOW_CONTROL]),
    .load_en(lp_word_valid),
    .load_data(lp_word[BIT_FLOW_CONTROL]),
    .q(lp_fcs)
  );

  logic [REG_W-1:0] lp_value;

  // Partner view; reserved pair reads zero
  always_comb
  begin
    lp_value = lp_ro;
    lp_value[RESV_HI:RESV_LO] = RST_RESV;
    lp_value[BIT_FLOW_CONTROL] = lp_fcs[0];
  end

  // -------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------
  logic [REG_W-1:0] id_value;

  // Fixed identifier word
  always_comb
  begin
    id_value = WORD_ZERO;
    id_value[ORG_HI:ORG_LO] = ORG_ID_LOW_BITS;
    id_value[MODEL_HI:MODEL_LO] = MODEL_NUMBER;
    id_value[REV_HI:REV_LO] = MODEL_REVISION;
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      mgmt_rdata <= WORD_ZERO;
    else if (mgmt_rd)
    begin
      case (mgmt_addr)
        OFF_PHY_IDENTIFIER_LOW: mgmt_rdata <= id_value;
        OFF_AUTONEG_ADVERTISE: mgmt_rdata <= adv_value;
        OFF_LINK_PARTNER_ABILITY: mgmt_rdata <= lp_value;
        default: mgmt_rdata <= WORD_ZERO;
      endcase
    end
  end

  // Read valid pulse
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      mgmt_rvalid <= 1'b0;
    else
      mgmt_rvalid <= mgmt_rd;
  end

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  AST_ID_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    mgmt_rd && mgmt_addr == OFF_PHY_IDENTIFIER_LOW |=> mgmt_rvalid &&
    mgmt_rdata[ORG_HI:ORG_LO] == ORG_ID_LOW_BITS)
    else $error("identifier org bits wrong");

  AST_ID_MODEL: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    mgmt_rd && mgmt_addr == OFF_PHY_IDENTIFIER_LOW |=>
    mgmt_rdata[MODEL_HI:MODEL_LO] == MODEL_NUMBER &&
    mgmt_rdata[REV_HI:REV_LO] == MODEL_REVISION)
    else $error("identifier model or revision wrong");

  AST_NP_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !adv_word[BIT_NEXT_PAGE] && !adv_word[BIT_FOUR_PAIR])
    else $error("next page or four-pair bit offered");

  AST_ACK_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
    an_ack_set ##1 !an_ack_clr |=> adv_word[BIT_ACK])
    else $error("local ack not offered after set");

  AST_ADV_WRITE: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    wr_adv |=> ##1 adv_word[ABIL_HI:ABIL_LO] ==
    $past(mgmt_wdata[ABIL_HI:ABIL_LO], 2))
    else $error("ability write not offered");

  AST_SEL_WRITE: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    wr_adv |=> ##1 adv_word[SEL_HI:SEL_LO] ==
    $past(mgmt_wdata[SEL_HI:SEL_LO], 2))
    else $error("selector write not offered");

  AST_LP_LOAD: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    lp_word_valid |=> lp_value[SEL_HI:SEL_LO] ==
    $past(lp_word[SEL_HI:SEL_LO]) &&
    lp_value[LP_ABIL_HI:ABIL_LO] == $past(lp_word[LP_ABIL_HI:ABIL_LO]) &&
    lp_value[BIT_NEXT_PAGE] == $past(lp_word[BIT_NEXT_PAGE]) &&
    lp_value[BIT_REMOTE_FAULT] == $past(lp_word[BIT_REMOTE_FAULT]))
    else $error("partner word not captured");

  AST_LP_RO: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_lp && !lp_word_valid && !lp_ack_valid |=>
    lp_ro == $past(lp_ro))
    else $error("partner read-only bits changed by write");

  AST_LP_FCS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_lp && !lp_word_valid |=> lp_fcs[0] == $past(mgmt_wdata[BIT_FLOW_CONTROL]))
    else $error("partner flow control not writable");

  AST_ACK_CLR: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    an_ack_clr && !an_ack_set ##1 !an_ack_set |=> !adv_word[BIT_ACK])
    else $error("local ack offered after clear");

  AST_FLAG_WRITE: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    wr_adv |=> ##1 adv_word[BIT_FLOW_CONTROL] ==
    $past(mgmt_wdata[BIT_FLOW_CONTROL], 2) &&
    adv_word[BIT_REMOTE_FAULT] == $past(mgmt_wdata[BIT_REMOTE_FAULT], 2))
    else $error("flag write not offered");

  AST_LP_ACK: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    lp_ack_valid |=> lp_ro[BIT_ACK] == $past(lp_ack))
    else $error("partner ack not captured");

  AST_RESET_DEFAULTS: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    $rose(reset_n) |-> (lp_ro == RST_PARTNER && lp_fcs == RST_FLAG_OFF) ##1
    (adv_word[ABIL_HI:ABIL_LO] == RST_ABIL &&
    adv_word[SEL_HI:SEL_LO] == RST_SELECTOR))
    else $error("defaults not restored after reset");
endmodule

`default_nettype wire

//--- mgmt_master.sv
// Management controller model for the register bank.
// Assumes strobes are sampled on the rising edge of clk_sys.
`timescale 1ns/1ns
`default_nettype none

module mgmt_master
  import phy_regs_pkg::*;
(
  input wire logic clk_sys, // System clock
  output logic [ADDR_W-1:0] mgmt_addr, // Register address
  output logic mgmt_wr, // Write strobe
  output logic [REG_W-1:0] mgmt_wdata, // Write data
  output logic mgmt_rd, // Read strobe
  input wire logic [REG_W-1:0] mgmt_rdata, // Read data
  input wire logic mgmt_rvalid // Read data valid
);
  // Idle bus at time zero
  initial
  begin
    mgmt_addr = 5'h00;
    mgmt_wr = 1'b0;
    mgmt_wdata = 16'h0000;
    mgmt_rd = 1'b0;
  end

  // One write; ack and reserved bits always sent as zero
  task automatic write(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge clk_sys);
    mgmt_addr <= a;
    mgmt_wdata <= d & 16'hA7FF;
    mgmt_wr <= 1'b1;
    @(posedge clk_sys);
    mgmt_wr <= 1'b0;
    mgmt_addr <= ~a;
    mgmt_wdata <= ~d;
  endtask

  // One read; waits a bounded time for the valid pulse
  task automatic read(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d,
                      output logic ok);
    int i;
    @(posedge clk_sys);
    mgmt_addr <= a;
    mgmt_rd <= 1'b1;
    @(posedge clk_sys);
    mgmt_rd <= 1'b0;
    mgmt_addr <= ~a;
    ok = 1'b0;
    d = 16'h0000;
    for (i = 0; i < 4 && !ok; i++)
    begin
      #1;
      if (mgmt_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d = mgmt_rdata;
      end
      else
        @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the identifier and negotiation registers.
// Assumes mgmt_master drives the management strobes.
`timescale 1ns/1ns
`default_nettype none

module testbench
  import phy_regs_pkg::*;
;
  localparam logic [15:0] ID_EXP = {6'h2A, 6'h15, 4'h3};
  localparam logic [15:0] MSK = 16'hE7FF;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] mgmt_addr;
  logic mgmt_wr, mgmt_rd, mgmt_rvalid, ok, ack;
  logic [REG_W-1:0] mgmt_wdata, mgmt_rdata, adv_word, rd, adv_w, r;
  logic an_ack_set = 1'b0;
  logic an_ack_clr = 1'b0;
  logic lp_word_valid = 1'b0;
  logic [REG_W-1:0] lp_word = 16'h0000;
  logic lp_ack_valid = 1'b0;
  logic lp_ack = 1'b0;
  logic [31:0] seed = 32'h44B1;
  int err_total = 0;
  int tests_run = 0;

  phy_id_autoneg_regs #(.ORG_ID_LOW_BITS(6'h2A), .MODEL_NUMBER(6'h15),
    .MODEL_REVISION(4'h3)) phy_id_autoneg_regs_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_wdata(mgmt_wdata), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .an_ack_set(an_ack_set),
    .an_ack_clr(an_ack_clr), .lp_word_valid(lp_word_valid),
    .lp_word(lp_word), .lp_ack_valid(lp_ack_valid), .lp_ack(lp_ack),
    .adv_word(adv_word));
  mgmt_master mgmt_master_i (.clk_sys(clk_sys), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rd(mgmt_rd),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

  // Clock, 4 ns period
  always #2 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Advertised word from written value and local ack
  function automatic logic [15:0] exp_adv(input logic [15:0] w, input logic a);
    return {1'b0, a, w[13], 2'b00, w[10], 1'b0, w[8:0]};
  endfunction

  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e,
                        input logic [15:0] m);
    mgmt_master_i.read(a, rd, ok);
    check("rvalid", {15'h0, ok}, 16'h0001);
    check($sformatf("reg_%h", a), rd & m, e & m);
  endtask

  task automatic lp_load(input logic [15:0] w);
    @(posedge clk_sys);
    lp_word <= w;
    lp_word_valid <= 1'b1;
    @(posedge clk_sys);
    lp_word_valid <= 1'b0;
    lp_word <= ~w;
  endtask

  task automatic neg_pulse(input logic s, input logic c, input logic v, input logic a);
    @(posedge clk_sys);
    an_ack_set <= s;
    an_ack_clr <= c;
    lp_ack_valid <= v;
    lp_ack <= a;
    @(posedge clk_sys);
    an_ack_set <= 1'b0;
    an_ack_clr <= 1'b0;
    lp_ack_valid <= 1'b0;
    lp_ack <= ~a;
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    summarize();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1;
    check("adv_word", adv_word, 16'h0000);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      adv_w = 16'h01E1;
      ack = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      check("adv_word", adv_word, 16'h01E1);
      rd_chk(5'h04, 16'h01E1, MSK);
      rd_chk(5'h05, 16'h0000, 16'hFFFF);
      if (k == 1)
        summarize();
      rd_chk(5'h03, ID_EXP, 16'hFFFF);
      rd_chk(5'h1F, 16'h0000, 16'hFFFF);
      mgmt_master_i.write(5'h03, 16'hFFFF);
      rd_chk(5'h03, ID_EXP, 16'hFFFF);
      mgmt_master_i.write(5'h04, 16'hFFFF);
      rd_chk(5'h04, 16'h25FF, MSK);
      check("adv_word", adv_word, 16'h25FF);
      mgmt_master_i.write(5'h04, 16'h0000);
      rd_chk(5'h04, 16'h0000, MSK);
      neg_pulse(1'b1, 1'b1, 1'b0, 1'b0);
      rd_chk(5'h04, 16'h4000, MSK);
      check("adv_word", adv_word, 16'h4000);
      neg_pulse(1'b0, 1'b1, 1'b0, 1'b0);
      rd_chk(5'h04, 16'h0000, MSK);
      lp_load(16'hFFFF);
      rd_chk(5'h05, 16'hFFFF, MSK);
      lp_load(16'h0000);
      neg_pulse(1'b0, 1'b0, 1'b1, 1'b1);
      rd_chk(5'h05, 16'h4000, MSK);
      mgmt_master_i.write(5'h05, 16'hFFFF);
      rd_chk(5'h05, 16'h4400, MSK);
      repeat (16)
      begin
        r = 16'(xs());
        adv_w = r & 16'hA7FF;
        mgmt_master_i.write(5'h04, r);
        rd_chk(5'h04, exp_adv(adv_w, ack), MSK);
        check("adv_word", adv_word, exp_adv(adv_w, ack));
        r = 16'(xs());
        lp_load(r);
        rd_chk(5'h05, r, MSK);
      end
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire
